// File: mpm_pkg.sv
// mpm_pkg: constants and types for the motor pulse monitor and current command block
// assumes 16-bit command words arrive already framed, address in the top nibble
package mpm_pkg;
	localparam int unsigned CLK_HZ           = 10_000_000;
	localparam int unsigned CMD_W            = 16;
	localparam int unsigned DATA_W           = 12;
	localparam int unsigned ADDR_LSB         = 12;
	localparam logic [3:0]  ADDR_CHOP        = 4'h1;
	localparam logic [3:0]  ADDR_TEST        = 4'h2;
	localparam logic [3:0]  ADDR_CH3         = 4'h3;
	localparam logic [3:0]  ADDR_CH4         = 4'h4;
	localparam logic [3:0]  ADDR_CH7         = 4'h7;
	// chopping word fields
	localparam int unsigned CHOP_CODE_LSB    = 0;
	localparam int unsigned CHOP_CODE_W      = 6;
	localparam int unsigned MON_MODE_BIT     = 6;
	localparam int unsigned MARK_CNT_BIT     = 7;
	localparam int unsigned MARK_POS_BIT     = 8;
	localparam logic [5:0]  CHOP_MIN_CODE    = 6'h08;
	localparam logic [5:0]  CHOP_MAX_CODE    = 6'h30;
	localparam int unsigned CHOP_BASE_KHZ    = 40;
	localparam int unsigned CHOP_STEP_KHZ    = 5;
	localparam int unsigned CHOP_MAX_KHZ     = 250;
	// printed table points that sit one step above the linear line
	localparam logic [5:0]  CHOP_BUMP_A      = 6'h23;
	localparam logic [5:0]  CHOP_BUMP_B      = 6'h29;
	localparam logic [5:0]  CHOP_BUMP_C      = 6'h2c;
	localparam int unsigned CHOP_BUMP_KHZ    = 5;
	// current word fields
	localparam int unsigned CUR_EN_BIT       = 0;
	localparam int unsigned CUR_DIR_BIT      = 1;
	localparam int unsigned CUR_REF_LSB      = 3;
	localparam int unsigned CUR_REF_W        = 5;
	localparam int unsigned REF_STEP_MV      = 20;
	localparam int unsigned REF_MIN_MV       = 100;
	localparam int unsigned REF_MAX_MV       = 500;
	localparam int unsigned MV_W             = 10;
	localparam int unsigned NUM_CC           = 3;
	localparam int unsigned STEPS_PER_CYCLE  = 8;

	typedef struct packed {
		logic           en;
		logic           dir_rev;
		logic [MV_W-1:0] ref_mv;
	} mpm_cc_t;

	typedef struct packed {
		logic       valid;
		logic [3:0] addr;
		logic [DATA_W-1:0] data;
	} mpm_cmd_t;
endpackage : mpm_pkg

// File: mpm_core.sv
// mpm_core: command decode, chopping reference, pulse monitor outputs, position marker,
// and constant-current channel settings for channels 3, 4 and 7
// assumes cmd words, step pulses and phase index come from same-clock logic
`timescale 1ns/1ns
//
// Contract
// - codes below 001000 give no chop pulses
// - chop reference drives stepping and constant-current pwm
// - monitor bit 0 follows micro step pulses
// - monitor bit 1 holds high during output; code drops it at the first pulse fall of the window
// - sync mode 50 percent duty, count rising
// - accel keeps monitor high time steady
// - multiplied pulse count appears on monitor
// - fixed-high output drops at pulse fall
// - marker once or four times per cycle
// - marker at full or equal current
// - equal-current marker silent after reset
// - current words use addresses 3,4,7
// - enable bit zero gives high impedance
// - direction bit selects forward or reverse
// - reference in 20 mV steps, clamped
// - chop code from data bits 0 to 5
// - micro step mode gates marker count
module mpm_core
	import mpm_pkg::*;
#(
	parameter int unsigned SYNC_HALF_CYC = 5
) (
	input  wire logic              core_clk,
	input  wire logic              reset,
	input  wire logic              cmd_valid,
	input  wire logic [CMD_W-1:0]  cmd_word,
	input  wire logic              micro_step_mode,
	input  wire logic              half_step_mode,
	input  wire logic              step_pulse_1,
	input  wire logic              step_pulse_2,
	input  wire logic              step_active_1,
	input  wire logic              step_active_2,
	input  wire logic [2:0]        phase_idx,
	output logic                   chop_pulse,
	output logic [7:0]             chop_khz,
	output logic                   pulse_monitor_out_1,
	output logic                   pulse_monitor_out_2,
	output logic                   position_marker_out_1,
	output logic                   position_marker_out_2,
	output logic [NUM_CC-1:0]      cc_drive_en,
	output logic [NUM_CC-1:0]      cc_drive_oe_n,
	output logic [NUM_CC-1:0]      cc_dir_rev,
	output mpm_cc_t [NUM_CC-1:0]   cc_setting,
	output logic [DATA_W-1:0]      test_word
);
	// command decode
	mpm_cmd_t cmd;
	assign cmd.valid = cmd_valid;
	assign cmd.addr  = cmd_word[CMD_W-1:ADDR_LSB];
	assign cmd.data  = cmd_word[DATA_W-1:0];

	wire wr_chop = cmd.valid && (cmd.addr == ADDR_CHOP);
	wire wr_test = cmd.valid && (cmd.addr == ADDR_TEST);
	wire [NUM_CC-1:0] wr_cc;
	assign wr_cc[0] = cmd.valid && (cmd.addr == ADDR_CH3);
	assign wr_cc[1] = cmd.valid && (cmd.addr == ADDR_CH4);
	assign wr_cc[2] = cmd.valid && (cmd.addr == ADDR_CH7);

	logic [DATA_W-1:0] chop_word_q;
	logic [DATA_W-1:0] test_word_q;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			chop_word_q <= '0;
			test_word_q <= '0;
		end else begin
			if (wr_chop)
				chop_word_q <= cmd.data;
			if (wr_test)
				test_word_q <= cmd.data;
		end
	end
	assign test_word = test_word_q;

	wire [CHOP_CODE_W-1:0] chop_code = chop_word_q[CHOP_CODE_LSB +: CHOP_CODE_W];
	wire mon_fixed_high = chop_word_q[MON_MODE_BIT];
	wire mark_four      = chop_word_q[MARK_CNT_BIT];
	wire mark_equal     = chop_word_q[MARK_POS_BIT];

	// off codes, linear 5 kHz steps capped at 250 kHz
	wire chop_off = chop_code < CHOP_MIN_CODE;
	// bumped codes keep the table monotonic: the next code repeats the bumped value
	wire chop_bump = (chop_code == CHOP_BUMP_A) || (chop_code == CHOP_BUMP_B) || (chop_code == CHOP_BUMP_C);
	wire [7:0] khz_lin = 8'(CHOP_BASE_KHZ) + 8'(CHOP_STEP_KHZ) * 8'(chop_code - CHOP_MIN_CODE) +
		(chop_bump ? 8'(CHOP_BUMP_KHZ) : 8'h00);
	wire [7:0] khz_sel = chop_off ? 8'h00 : (chop_code >= CHOP_MAX_CODE) ? 8'(CHOP_MAX_KHZ) : khz_lin;

	// half period in cycles = CLK_HZ / (2 * khz * 1000); truncation keeps rate at or above target
	logic [15:0] chop_cnt_q;
	logic        chop_q;
	logic [7:0]  khz_q;
	wire  [15:0] chop_half = (khz_sel == 8'h00) ? 16'h0001 :
		16'((CLK_HZ / 2000) / int'(khz_sel));
	// single chop reference for all constant-current pwm
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			chop_cnt_q <= '0;
			chop_q     <= 1'b0;
			khz_q      <= '0;
		end else begin
			khz_q <= khz_sel;
			if (chop_off) begin
				chop_cnt_q <= '0;
				chop_q     <= 1'b0;
			end else if (chop_cnt_q + 16'h0001 >= chop_half) begin
				chop_cnt_q <= '0;
				chop_q     <= ~chop_q;
			end else begin
				chop_cnt_q <= chop_cnt_q + 16'h0001;
			end
		end
	end
	assign chop_pulse = chop_q;
	assign chop_khz   = khz_q;

	// monitor: step pulses already carry m-multiplied count and steady high time
	logic [1:0] mon_q;
	wire  [1:0] step_pulse  = {step_pulse_2, step_pulse_1};
	wire  [1:0] step_active = {step_active_2, step_active_1};
	logic [1:0] pulse_prev_q;
	logic [1:0] active_prev_q;
	genvar g;
	for (g = 0; g < 2; g++) begin : g_mon
		// fixed-high output ends at sync pulse fall
		wire fall  = pulse_prev_q[g] && !step_pulse[g];
		// the block cannot see which pulse is last, so a fall ends the whole window
		wire rearm = mon_q[g] || !active_prev_q[g];
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				mon_q[g]         <= 1'b0;
				pulse_prev_q[g]  <= 1'b0;
				active_prev_q[g] <= 1'b0;
			end else begin
				pulse_prev_q[g]  <= step_pulse[g];
				active_prev_q[g] <= step_active[g];
				if (!mon_fixed_high)
					mon_q[g] <= step_pulse[g];
				// fixed-high while output runs, low after the fall
				else
					mon_q[g] <= step_active[g] && !fall && rearm;
			end
		end
	end
	assign pulse_monitor_out_1 = mon_q[0];
	assign pulse_monitor_out_2 = mon_q[1];

	// position marker: phase_idx counts eighth-cycles; even = one phase 100%, odd = equal
	logic [2:0] phase_prev_q;
	logic       phase_seen_q;
	logic [1:0] mark_q;
	wire phase_moved = phase_seen_q && (phase_idx != phase_prev_q);
	wire at_pos = mark_equal ? phase_idx[0] : !phase_idx[0];
	// count select only in micro step
	wire once_ok = !(micro_step_mode && !mark_four) || (phase_idx[2:1] == 2'b00);
	wire pos_mode = micro_step_mode || half_step_mode;
	wire mark_hit = pos_mode && phase_moved && at_pos && once_ok;
	always_ff @(posedge core_clk or posedge reset) begin
		if (reset) begin
			phase_prev_q <= '0;
			// no reference phase after reset, so no marker of either position on the first cycle
			phase_seen_q <= 1'b0;
			mark_q       <= '0;
		end else begin
			phase_prev_q <= phase_idx;
			phase_seen_q <= 1'b1;
			// shared placement for both markers
			mark_q <= {2{mark_hit}};
		end
	end
	assign position_marker_out_1 = mark_q[0];
	assign position_marker_out_2 = mark_q[1];

	// constant-current channels
	mpm_cc_t [NUM_CC-1:0] cc_q;
	// own flop for the enable pin so it comes straight from a register
	logic    [NUM_CC-1:0] cc_oe_n_q;
	for (g = 0; g < NUM_CC; g++) begin : g_cc
		wire [4:0] code = cmd.data[CUR_REF_LSB +: CUR_REF_W];
		wire [MV_W-1:0] raw_mv = MV_W'(code) * MV_W'(REF_STEP_MV);
		wire [MV_W-1:0] clamp_mv = (raw_mv < MV_W'(REF_MIN_MV)) ? MV_W'(REF_MIN_MV) :
			(raw_mv > MV_W'(REF_MAX_MV)) ? MV_W'(REF_MAX_MV) : raw_mv;
		always_ff @(posedge core_clk or posedge reset) begin
			if (reset) begin
				cc_q[g]      <= '{en: 1'b0, dir_rev: 1'b0, ref_mv: MV_W'(REF_MIN_MV)};
				cc_oe_n_q[g] <= 1'b1;
			end else if (wr_cc[g]) begin
				cc_oe_n_q[g]    <= ~cmd.data[CUR_EN_BIT];
				cc_q[g].en      <= cmd.data[CUR_EN_BIT];
				cc_q[g].dir_rev <= cmd.data[CUR_DIR_BIT];
				cc_q[g].ref_mv  <= clamp_mv;
			end
		end
		assign cc_drive_en[g]   = cc_q[g].en;
		assign cc_drive_oe_n[g] = cc_oe_n_q[g];
		assign cc_dir_rev[g]    = cc_q[g].dir_rev;
	end
	assign cc_setting = cc_q;

	// checks
	chk_chop_off_idle: assert property (@(posedge core_clk) disable iff (reset)
		chop_off |=> ##1 !chop_pulse) else $error("chop ran on off code");
	chk_chop_cap_khz: assert property (@(posedge core_clk) disable iff (reset)
		chop_khz <= 8'(CHOP_MAX_KHZ)) else $error("chop above cap");
	chk_sync_follow: assert property (@(posedge core_clk) disable iff (reset)
		!mon_fixed_high |=> (pulse_monitor_out_1 == $past(step_pulse_1))) else $error("sync mismatch");
	chk_fixed_high_on: assert property (@(posedge core_clk) disable iff (reset)
		(mon_fixed_high && step_active_1 && !g_mon[0].fall && g_mon[0].rearm) |=> pulse_monitor_out_1)
		else $error("fixed high dropped");
	chk_fixed_fall_drop: assert property (@(posedge core_clk) disable iff (reset)
		(mon_fixed_high && g_mon[0].fall) |=> !pulse_monitor_out_1) else $error("no drop at fall");
	chk_marker_pair_same: assert property (@(posedge core_clk) disable iff (reset)
		position_marker_out_1 == position_marker_out_2) else $error("markers differ");
	chk_marker_pos_sel: assert property (@(posedge core_clk) disable iff (reset)
		position_marker_out_1 |-> ($past(phase_idx[0]) == $past(mark_equal))) else $error("marker position");
	chk_cc_hiz_off: assert property (@(posedge core_clk) disable iff (reset)
		(wr_cc[0] && !cmd.data[CUR_EN_BIT]) |=> cc_drive_oe_n[0]) else $error("ch3 not hi-z");
	chk_cc_dir_take: assert property (@(posedge core_clk) disable iff (reset)
		wr_cc[2] |=> (cc_dir_rev[2] == $past(cmd.data[CUR_DIR_BIT]))) else $error("ch7 dir");
	chk_cc_ref_range: assert property (@(posedge core_clk) disable iff (reset)
		(cc_setting[1].ref_mv >= MV_W'(REF_MIN_MV)) && (cc_setting[1].ref_mv <= MV_W'(REF_MAX_MV)))
		else $error("ref out of range");
	chk_chop_hold_word: assert property (@(posedge core_clk) disable iff (reset)
		!wr_chop |=> $stable(chop_word_q)) else $error("chop word changed");
	cov_chop_run: cover property (@(posedge core_clk) disable iff (reset) $rose(chop_pulse));
	cov_marker_hit: cover property (@(posedge core_clk) disable iff (reset) position_marker_out_1);
	cov_fixed_mode: cover property (@(posedge core_clk) disable iff (reset) mon_fixed_high && pulse_monitor_out_2);
	cov_cc_on: cover property (@(posedge core_clk) disable iff (reset) cc_drive_en[1]);
	cov_marker_equal: cover property (@(posedge core_clk) disable iff (reset) position_marker_out_1 && mark_equal);

	// chop reference checks
	chk_chop_khz_off: assert property (@(posedge core_clk) disable iff (reset)
		chop_off |=> (chop_khz == 8'h00))
		else $error("chop khz not zero on off code");
	chk_chop_max_code: assert property (@(posedge core_clk) disable iff (reset)
		(chop_code >= CHOP_MAX_CODE) |=> (chop_khz == 8'(CHOP_MAX_KHZ)))
		else $error("top codes not at cap");
	chk_chop_min_code: assert property (@(posedge core_clk) disable iff (reset)
		(chop_code == CHOP_MIN_CODE) |=> (chop_khz == 8'(CHOP_BASE_KHZ)))
		else $error("first code not at base");
	chk_chop_cnt_clear: assert property (@(posedge core_clk) disable iff (reset)
		chop_off |=> (chop_cnt_q == 16'h0000))
		else $error("chop counter ran while off");
	chk_chop_take_word: assert property (@(posedge core_clk) disable iff (reset)
		wr_chop |=> (chop_word_q == $past(cmd.data)))
		else $error("chop word not taken");

	// monitor checks
	chk_sync_follow_2: assert property (@(posedge core_clk) disable iff (reset)
		!mon_fixed_high |=> (pulse_monitor_out_2 == $past(step_pulse_2)))
		else $error("sync mismatch on output 2");
	chk_fixed_high_2: assert property (@(posedge core_clk) disable iff (reset)
		(mon_fixed_high && step_active_2 && !g_mon[1].fall && g_mon[1].rearm) |=> pulse_monitor_out_2)
		else $error("fixed high dropped on output 2");
	chk_fixed_drop_2: assert property (@(posedge core_clk) disable iff (reset)
		(mon_fixed_high && g_mon[1].fall) |=> !pulse_monitor_out_2)
		else $error("no drop at fall on output 2");
	chk_fixed_idle_low: assert property (@(posedge core_clk) disable iff (reset)
		(mon_fixed_high && !step_active_1) |=> !pulse_monitor_out_1)
		else $error("fixed output high while idle");
	chk_fixed_idle_low_2: assert property (@(posedge core_clk) disable iff (reset)
		(mon_fixed_high && !step_active_2) |=> !pulse_monitor_out_2)
		else $error("fixed output 2 high while idle");

	// marker checks
	chk_marker_reset_quiet: assert property (@(posedge core_clk) disable iff (reset)
		!phase_seen_q |=> !position_marker_out_1)
		else $error("marker right after reset");
	chk_marker_needs_move: assert property (@(posedge core_clk) disable iff (reset)
		(phase_idx == phase_prev_q) |=> !position_marker_out_1)
		else $error("marker without phase move");
	chk_marker_mode_gate: assert property (@(posedge core_clk) disable iff (reset)
		!(micro_step_mode || half_step_mode) |=> !position_marker_out_1)
		else $error("marker outside position modes");
	chk_marker_once_cycle: assert property (@(posedge core_clk) disable iff (reset)
		(position_marker_out_1 && $past(micro_step_mode) && !$past(mark_four)) |-> ($past(phase_idx[2:1]) == 2'b00))
		else $error("extra marker in once mode");

	// constant-current checks
	chk_cc_hiz_ch4: assert property (@(posedge core_clk) disable iff (reset)
		(wr_cc[1] && !cmd.data[CUR_EN_BIT]) |=> cc_drive_oe_n[1])
		else $error("ch4 not hi-z");
	chk_cc_hiz_ch7: assert property (@(posedge core_clk) disable iff (reset)
		(wr_cc[2] && !cmd.data[CUR_EN_BIT]) |=> cc_drive_oe_n[2])
		else $error("ch7 not hi-z");
	chk_cc_on_ch3: assert property (@(posedge core_clk) disable iff (reset)
		(wr_cc[0] && cmd.data[CUR_EN_BIT]) |=> (cc_drive_en[0] && !cc_drive_oe_n[0]))
		else $error("ch3 not on");
	chk_cc_on_ch7: assert property (@(posedge core_clk) disable iff (reset)
		(wr_cc[2] && cmd.data[CUR_EN_BIT]) |=> (cc_drive_en[2] && !cc_drive_oe_n[2]))
		else $error("ch7 not on");
	chk_cc_oe_pair: assert property (@(posedge core_clk) disable iff (reset)
		cc_drive_oe_n == ~cc_drive_en)
		else $error("enable and hi-z disagree");
	chk_cc_dir_ch3: assert property (@(posedge core_clk) disable iff (reset)
		wr_cc[0] |=> (cc_dir_rev[0] == $past(cmd.data[CUR_DIR_BIT])))
		else $error("ch3 dir");
	chk_cc_dir_ch4: assert property (@(posedge core_clk) disable iff (reset)
		wr_cc[1] |=> (cc_dir_rev[1] == $past(cmd.data[CUR_DIR_BIT])))
		else $error("ch4 dir");
	chk_cc_ref_low: assert property (@(posedge core_clk) disable iff (reset)
		(wr_cc[0] && (g_cc[0].raw_mv < MV_W'(REF_MIN_MV))) |=> (cc_setting[0].ref_mv == MV_W'(REF_MIN_MV)))
		else $error("low reference not clamped");
	chk_cc_ref_high: assert property (@(posedge core_clk) disable iff (reset)
		(wr_cc[0] && (g_cc[0].raw_mv > MV_W'(REF_MAX_MV))) |=> (cc_setting[0].ref_mv == MV_W'(REF_MAX_MV)))
		else $error("high reference not clamped");
	chk_cc_ref_range_2: assert property (@(posedge core_clk) disable iff (reset)
		(cc_setting[2].ref_mv >= MV_W'(REF_MIN_MV)) && (cc_setting[2].ref_mv <= MV_W'(REF_MAX_MV)))
		else $error("ch7 ref out of range");
	chk_cc_hold_ch3: assert property (@(posedge core_clk) disable iff (reset)
		!wr_cc[0] |=> $stable(cc_setting[0]))
		else $error("ch3 setting changed");
	chk_cc_unmapped: assert property (@(posedge core_clk) disable iff (reset)
		(cmd.valid && !(|wr_cc)) |=> $stable(cc_setting))
		else $error("other address moved a channel");

	// test word checks
	chk_test_take: assert property (@(posedge core_clk) disable iff (reset)
		wr_test |=> (test_word == $past(cmd.data)))
		else $error("test word not taken");
	chk_test_hold: assert property (@(posedge core_clk) disable iff (reset)
		!wr_test |=> $stable(test_word))
		else $error("test word changed");
endmodule : mpm_core

// File: mpm_host.sv
// mpm_host: host model that writes 16-bit command words
// assumes a free-running core_clk; words change 1 ns after the edge
`timescale 1ns/1ns
module mpm_host
	import mpm_pkg::*;
(
	input  wire logic        core_clk,
	output logic             cmd_valid,
	output logic [CMD_W-1:0] cmd_word
);
	initial begin
		cmd_valid = 1'b0;
		cmd_word = 16'h0000;
	end
	// idle word is inverted so a stale word never looks like a fresh one
	task automatic send(input logic [3:0] a, input logic [DATA_W-1:0] d);
		logic [DATA_W-1:0] v;
		begin
			v = d;
			if (a == ADDR_CH3 || a == ADDR_CH4 || a == ADDR_CH7)
				v = d & 12'h0fb;
			// no test word is ever programmed from here: its data is forced to zero
			if (a == ADDR_TEST)
				v = 12'h000;
			@(posedge core_clk);
			#1 cmd_valid = 1'b1;
			cmd_word = {a, v};
			@(posedge core_clk);
			#1 cmd_valid = 1'b0;
			cmd_word = ~cmd_word;
		end
	endtask : send
endmodule : mpm_host

// File: test_motor_pulse_monitor_and_current_cmd.sv
// test_motor_pulse_monitor_and_current_cmd: self-checking bench for mpm_core
// assumes mpm_host sends commands; a per-cycle model predicts every output except chop_pulse, whose toggles are counted
`timescale 1ns/1ns
module test_motor_pulse_monitor_and_current_cmd;
	import mpm_pkg::*;
	logic             core_clk = 1'b0, reset = 1'b1, ms = 1'b0, hs = 1'b0;
	logic             sp1 = 1'b0, sp2 = 1'b0, sa1 = 1'b0, sa2 = 1'b0;
	logic             cmd_valid, chp, pm1, pm2, mk1, mk2, pv, m1, m2, p1, p2, a1, a2;
	logic [CMD_W-1:0] cmd_word;
	logic [2:0]       ph = 3'h0, php, en, oe_n, dir;
	logic [7:0]       khz;
	logic [11:0]      tw_o;
	mpm_cc_t [2:0]    cs;
	logic [31:0]      rx = 32'd70681;
	logic [1:0]       seq[7] = '{2'h0, 2'h3, 2'h3, 2'h3, 2'h2, 2'h2, 2'h0};
	int               codes[9] = '{0, 7, 8, 24, 35, 41, 44, 48, 63};
	int               err_count = 0, checked = 0, cyc = 0, d6, d7, d8, kh, tw, ce[3], cd[3], cr[3];
	always #50 core_clk = ~core_clk;
	mpm_host host (.core_clk(core_clk), .cmd_valid(cmd_valid), .cmd_word(cmd_word));
	mpm_core dut (.core_clk(core_clk), .reset(reset), .cmd_valid(cmd_valid), .cmd_word(cmd_word),
		.micro_step_mode(ms), .half_step_mode(hs), .step_pulse_1(sp1), .step_pulse_2(sp2),
		.step_active_1(sa1), .step_active_2(sa2), .phase_idx(ph), .chop_pulse(chp), .chop_khz(khz),
		.pulse_monitor_out_1(pm1), .pulse_monitor_out_2(pm2), .position_marker_out_1(mk1),
		.position_marker_out_2(mk2), .cc_drive_en(en), .cc_drive_oe_n(oe_n), .cc_dir_rev(dir),
		.cc_setting(cs), .test_word(tw_o));
	function automatic logic [31:0] xr();
		rx ^= rx << 13;
		rx ^= rx >> 17;
		rx ^= rx << 5;
		return rx;
	endfunction : xr
	task automatic check(input logic [15:0] got, input logic [15:0] exp);
		checked++;
		if (got !== exp) begin
			err_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : check
	task automatic report_and_stop();
		$display("checks=%0d errors=%0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask : report_and_stop
	// whole run needs about 2700 cycles
	always @(posedge core_clk) begin
		cyc++;
		if (cyc == 10000) begin
			err_count++;
			report_and_stop();
		end
	end
	task automatic tick();
		logic [2:0] q;
		logic s1, s2, b1, b2, mq, hq, e1, e2, mk;
		begin
			{q, s1, s2, b1, b2, mq, hq} = {ph, sp1, sp2, sa1, sa2, ms, hs};
			@(posedge core_clk);
			#1;
			e1 = d6 ? b1 && !(p1 && !s1) && (m1 || !a1) : s1;
			e2 = d6 ? b2 && !(p2 && !s2) && (m2 || !a2) : s2;
			mk = pv && q != php && (mq || hq) && q[0] == d8[0] && !(mq && !d7 && q[2:1] != 2'b00);
			{m1, m2, p1, p2, a1, a2, php, pv} = {e1, e2, s1, s2, b1, b2, q, 1'b1};
			check(16'({pm1, pm2}), 16'({e1, e2}));
			check(16'({mk1, mk2}), 16'({mk, mk}));
		end
	endtask : tick
	task automatic check_all();
		check(16'(khz), 16'(kh));
		check(16'(tw_o), 16'(tw));
		for (int j = 0; j < 3; j++) begin
			check(16'(cs[j]), 16'({ce[j][0], cd[j][0], 10'(cr[j])}));
			check(16'({en[j], oe_n[j], dir[j]}), 16'({ce[j][0], !ce[j][0], cd[j][0]}));
		end
	endtask : check_all
	task automatic do_reset();
		reset = 1'b1;
		repeat (5) @(posedge core_clk);
		#1 reset = 1'b0;
		{pv, m1, m2, p1, p2, a1, a2} = 7'h0;
		{d6, d7, d8, kh, tw} = 160'h0;
		for (int j = 0; j < 3; j++)
			{ce[j], cd[j], cr[j]} = {32'd0, 32'd0, 32'd100};
	endtask : do_reset
	task automatic wr(input logic [3:0] a, input logic [11:0] d);
		int c;
		int i;
		begin
			fork
				host.send(a, d);
				begin
					tick();
					tick();
				end
			join
			c = int'(d[5:0]);
			i = a == ADDR_CH3 ? 0 : a == ADDR_CH4 ? 1 : 2;
			if (a == ADDR_CHOP) begin
				d6 = d[6];
				d7 = d[7];
				d8 = d[8];
				kh = c < 8 ? 0 : c >= 48 ? 250 : 40 + 5 * (c - 8) + ((c == 35 || c == 41 || c == 44) ? 5 : 0);
			end
			if (a == ADDR_CH3 || a == ADDR_CH4 || a == ADDR_CH7) begin
				ce[i] = d[0];
				cd[i] = d[1];
				cr[i] = d[7:3] * 20 < 100 ? 100 : d[7:3] * 20 > 500 ? 500 : d[7:3] * 20;
			end
			tick();
			check_all();
		end
	endtask : wr
	initial begin
		int n, e;
		logic c0;
		do_reset();
		check_all();
		foreach (codes[k]) begin
			wr(ADDR_CHOP, 12'(codes[k]));
			n = 0;
			for (int t = 0; t < 250; t++) begin
				c0 = chp;
				tick();
				n += int'(chp != c0);
			end
			e = kh ? 250 / (5000 / kh) : 0;
			check(16'(kh ? n + 1 >= e && n <= e + 1 : n == 0), 16'h1);
		end
		repeat (60) wr(4'(xr()), 12'(xr()));
		wr(ADDR_CHOP, 12'h008);
		{sa1, sa2} = 2'b11;
		repeat (40) begin
			{sp1, sp2} = 2'(xr());
			tick();
		end
		{sp1, sp2, sa1, sa2} = 4'h0;
		wr(ADDR_CHOP, 12'h048);
		repeat (2) foreach (seq[k]) begin
			{sa1, sp1, sa2, sp2} = {seq[k], seq[k]};
			tick();
		end
		for (int k = 0; k < 8; k++) begin
			{ms, hs} = k[2] ? 2'b01 : 2'b10;
			wr(ADDR_CHOP, 12'({k[1:0], 7'h08}));
			repeat (20) begin
				ph = ph + 3'(xr() & 1);
				tick();
			end
		end
		{ms, hs, ph} = {2'b10, 3'h3};
		do_reset();
		wr(ADDR_CHOP, 12'h188);
		repeat (4) tick();
		ph = 3'h5;
		repeat (3) tick();
		report_and_stop();
	end
endmodule : test_motor_pulse_monitor_and_current_cmd
